// ===== ipbm_pkg.sv
// Overview of operation
// - Bus runs at 4.096, 8.192, 16.384 MHz
// - Host enables receive elastic stores beforehand
// - Each device holds one exclusive bus position
// - Frame sync from backplane or first device
// - Non-generating devices take frame sync in
// - Count from sync, drive only own slots
// - Channel interleave: one channel per device, rotating
// - Channel interleave tolerates asynchronous devices, slips
// - Frame interleave: one whole frame per device
// - Frame interleave only when all synchronous
// - Position field n selects slot n+1
// - Control bit 3 enables interleaved operation
// - Control bit 4: channel or frame style
// - Bits 5-6 give two, four, eight devices
// - Software writes zero to control bit 7
package ipbm_pkg;
   // Register indices; byte address is four times the index
   localparam logic [9:0]  IPBM_CTRL_IDX    = 10'h0c5;
   localparam logic [9:0]  IPBM_DEVCFG_IDX  = 10'h0c6;
   localparam logic [9:0]  IPBM_STAT_IDX    = 10'h0c7;
   // Control register layout
   localparam int          IPBM_POS_LSB     = 0;
   localparam int          IPBM_POS_W       = 3;
   localparam int          IPBM_EN_BIT      = 3;
   localparam int          IPBM_STYLE_BIT   = 4;
   localparam int          IPBM_SIZE_LSB    = 5;
   localparam logic [7:0]  IPBM_CTRL_MASK   = 8'h7f;
   localparam logic [7:0]  IPBM_CTRL_RESET  = 8'h00;
   localparam int          IPBM_FSM_BIT     = 0;
   localparam logic [7:0]  IPBM_DEVCFG_RST  = 8'h00;
   // Bus size codes
   localparam logic [1:0]  IPBM_SIZE_TWO    = 2'h0;
   localparam logic [1:0]  IPBM_SIZE_FOUR   = 2'h1;
   localparam logic [1:0]  IPBM_SIZE_EIGHT  = 2'h2;
   localparam logic [1:0]  IPBM_SIZE_RSVD   = 2'h3;
   // Frame geometry
   localparam int          IPBM_CHANNELS    = 32;
   localparam int          IPBM_CHAN_W      = 5;
   localparam int          IPBM_BYTE_BITS   = 8;
   localparam int          IPBM_FRAME_BITS  = IPBM_CHANNELS * IPBM_BYTE_BITS;
   localparam int          IPBM_PCNT_W      = 11;
   localparam int          IPBM_FLEN_W      = 12;
   // Bus rates and bit-tick divider
   localparam int          IPBM_CLK_KHZ     = 200000;
   localparam int          IPBM_RATE2_KHZ   = 4096;
   localparam int          IPBM_RATE4_KHZ   = 8192;
   localparam int          IPBM_RATE8_KHZ   = 16384;
   localparam int          IPBM_DIV_FAST    = IPBM_CLK_KHZ / IPBM_RATE8_KHZ;
   // AXI responses
   localparam logic [1:0]  IPBM_RESP_OKAY   = 2'h0;
   localparam logic [1:0]  IPBM_RESP_SLVERR = 2'h2;
endpackage

// ===== ipbm_if.sv
`timescale 1ns/1ps
// Shared PCM bus between one transceiver and the backplane
interface ipbm_if;
   logic bit_tick;
   logic bp_fs_o;
   logic bp_fs_oe_n;
   logic dev_fs_o;
   logic dev_fs_oe_n;
   logic dev_data_o;
   logic dev_data_oe_n;
   logic frame_sync;
   logic bus_data;

   // Wire levels; undriven lines read low
   assign frame_sync = (!bp_fs_oe_n && bp_fs_o) || (!dev_fs_oe_n && dev_fs_o);
   assign bus_data   = !dev_data_oe_n && dev_data_o;

   modport dev (
      input  bit_tick,
      input  frame_sync,
      input  bus_data,
      output dev_fs_o,
      output dev_fs_oe_n,
      output dev_data_o,
      output dev_data_oe_n
   );
   modport bp (
      output bit_tick,
      output bp_fs_o,
      output bp_fs_oe_n,
      input  frame_sync,
      input  bus_data
   );
endinterface

// ===== ipbm_dev.sv
`timescale 1ns/1ps
module ipbm_dev #(
   parameter int ADDR_W = 12
) (
   // Clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // AXI4-Lite write channels
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic [2:0]        awprot,
   input  wire logic              wvalid,
   output logic                   wready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   output logic                   bvalid,
   input  wire logic              bready,
   output logic [1:0]             bresp,
   // AXI4-Lite read channels
   input  wire logic              arvalid,
   output logic                   arready,
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic [2:0]        arprot,
   output logic                   rvalid,
   input  wire logic              rready,
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   // Receive channel source, fed from the elastic store
   output logic [4:0]             chan_index,
   input  wire logic [7:0]        chan_data,
   output logic                   chan_take,
   // Shared PCM bus
   ipbm_if.dev                    bus
);
   localparam int SLOT_W = ipbm_pkg::IPBM_PCNT_W - 3;

   logic                          aw_hold_r;
   logic                          w_hold_r;
   logic [ADDR_W-1:0]             awaddr_r;
   logic [31:0]                   wdata_r;
   logic [3:0]                    wstrb_r;
   logic                          bvalid_r;
   logic [1:0]                    bresp_r;
   logic                          rvalid_r;
   logic [31:0]                   rdata_r;
   logic [1:0]                    rresp_r;
   logic [7:0]                    ctrl_r;
   logic [7:0]                    devcfg_r;
   logic [ipbm_pkg::IPBM_PCNT_W-1:0] pos_r;
   logic                          locked_r;
   logic [7:0]                    shift_r;
   logic                          data_r;
   logic                          data_oe_n_r;
   logic                          fs_r;
   logic                          wr_fire;
   logic [9:0]                    wr_idx;
   logic [9:0]                    rd_idx;
   logic [2:0]                    position;
   logic                          ilv_en;
   logic                          style_frame;
   logic [1:0]                    bus_size;
   logic                          size_rsvd;
   logic                          fs_master;
   logic [1:0]                    shamt;
   logic [ipbm_pkg::IPBM_FLEN_W-1:0] flen;
   logic [ipbm_pkg::IPBM_PCNT_W-1:0] last_pos;
   logic [ipbm_pkg::IPBM_PCNT_W-1:0] pos_nxt;
   logic [SLOT_W-1:0]             slot;
   logic [SLOT_W-1:0]             owner;
   logic [4:0]                    ch;
   logic                          owned;
   logic                          locked_nxt;

   // Handshakes; one write and one read in flight
   assign awready = !aw_hold_r && !bvalid_r;
   assign wready  = !w_hold_r && !bvalid_r;
   assign bvalid  = bvalid_r;
   assign bresp   = bresp_r;
   assign arready = !rvalid_r;
   assign rvalid  = rvalid_r;
   assign rdata   = rdata_r;
   assign rresp   = rresp_r;
   assign wr_fire = aw_hold_r && w_hold_r;
   assign wr_idx  = 10'(awaddr_r >> 2);
   assign rd_idx  = 10'(araddr >> 2);

   // Write address and data held until both arrive, in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_r <= 1'b0;
         w_hold_r  <= 1'b0;
         awaddr_r  <= '0;
         wdata_r   <= 32'h0;
         wstrb_r   <= 4'h0;
         bvalid_r  <= 1'b0;
         bresp_r   <= ipbm_pkg::IPBM_RESP_OKAY;
      end else begin
         if (awvalid && awready) begin
            aw_hold_r <= 1'b1;
            awaddr_r  <= awaddr;
         end
         if (wvalid && wready) begin
            w_hold_r <= 1'b1;
            wdata_r  <= wdata;
            wstrb_r  <= wstrb;
         end
         if (wr_fire) begin
            aw_hold_r <= 1'b0;
            w_hold_r  <= 1'b0;
            bvalid_r  <= 1'b1;
            if (wr_idx == ipbm_pkg::IPBM_CTRL_IDX || wr_idx == ipbm_pkg::IPBM_DEVCFG_IDX ||
                wr_idx == ipbm_pkg::IPBM_STAT_IDX) begin
               bresp_r <= ipbm_pkg::IPBM_RESP_OKAY;
            end else begin
               bresp_r <= ipbm_pkg::IPBM_RESP_SLVERR;
            end
         end else if (bvalid_r && bready) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   // Register stores; status ignores writes, top control bit kept zero
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_r   <= ipbm_pkg::IPBM_CTRL_RESET;
         devcfg_r <= ipbm_pkg::IPBM_DEVCFG_RST;
      end else if (wr_fire && wstrb_r[0]) begin
         if (wr_idx == ipbm_pkg::IPBM_CTRL_IDX) begin
            ctrl_r <= wdata_r[7:0] & ipbm_pkg::IPBM_CTRL_MASK;
         end
         if (wr_idx == ipbm_pkg::IPBM_DEVCFG_IDX) begin
            devcfg_r <= {7'h0, wdata_r[ipbm_pkg::IPBM_FSM_BIT]};
         end
      end
   end

   // Read answer one cycle after the address is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_r <= 1'b0;
         rdata_r  <= 32'h0;
         rresp_r  <= ipbm_pkg::IPBM_RESP_OKAY;
      end else if (arvalid && arready) begin
         rvalid_r <= 1'b1;
         rresp_r  <= ipbm_pkg::IPBM_RESP_OKAY;
         if (rd_idx == ipbm_pkg::IPBM_CTRL_IDX) begin
            rdata_r <= {24'h0, ctrl_r};
         end else if (rd_idx == ipbm_pkg::IPBM_DEVCFG_IDX) begin
            rdata_r <= {24'h0, devcfg_r};
         end else if (rd_idx == ipbm_pkg::IPBM_STAT_IDX) begin
            rdata_r <= {28'h0, !bus.dev_fs_oe_n, size_rsvd, !data_oe_n_r, locked_r};
         end else begin
            rdata_r <= 32'h0;
            rresp_r <= ipbm_pkg::IPBM_RESP_SLVERR;
         end
      end else if (rvalid_r && rready) begin
         rvalid_r <= 1'b0;
      end
   end

   // Control fields
   assign position    = ctrl_r[ipbm_pkg::IPBM_POS_LSB +: ipbm_pkg::IPBM_POS_W];
   assign ilv_en      = ctrl_r[ipbm_pkg::IPBM_EN_BIT];
   assign style_frame = ctrl_r[ipbm_pkg::IPBM_STYLE_BIT];
   assign bus_size    = ctrl_r[ipbm_pkg::IPBM_SIZE_LSB +: 2];
   assign size_rsvd   = bus_size == ipbm_pkg::IPBM_SIZE_RSVD;
   assign fs_master   = devcfg_r[ipbm_pkg::IPBM_FSM_BIT];
   assign shamt       = bus_size + 2'h1;

   // Bus frame length and next bit position counted from frame sync
   always_comb begin
      if (ilv_en && !size_rsvd) begin
         flen = ipbm_pkg::IPBM_FLEN_W'(ipbm_pkg::IPBM_FRAME_BITS) << shamt;
      end else begin
         flen = ipbm_pkg::IPBM_FLEN_W'(ipbm_pkg::IPBM_FRAME_BITS);
      end
      last_pos = ipbm_pkg::IPBM_PCNT_W'(flen - 12'h1);
      if (bus.frame_sync) begin
         pos_nxt = '0;
      end else if (pos_r >= last_pos) begin
         pos_nxt = '0;
      end else begin
         pos_nxt = pos_r + 11'h1;
      end
   end

   // Slot ownership for the bit about to be driven
   always_comb begin
      slot  = pos_nxt[ipbm_pkg::IPBM_PCNT_W-1:3];
      owner = '0;
      ch    = slot[ipbm_pkg::IPBM_CHAN_W-1:0];
      owned = 1'b0;
      if (!ilv_en) begin
         owned = slot < SLOT_W'(ipbm_pkg::IPBM_CHANNELS);
      end else if (size_rsvd) begin
         owned = 1'b0;
      end else if (!style_frame) begin
         owner = slot & ((8'h1 << shamt) - 8'h1);
         ch    = 5'(slot >> shamt);
         owned = owner == {5'h0, position};
      end else begin
         owner = 8'(slot >> ipbm_pkg::IPBM_CHAN_W);
         owned = owner == {5'h0, position};
      end
   end

   assign locked_nxt = locked_r || bus.frame_sync;
   assign chan_index = ch;
   // Elastic store upstream absorbs slips; byte taken at slot start
   assign chan_take  = bus.bit_tick && owned && locked_nxt && (pos_nxt[2:0] == 3'h0);

   // Bit position and sync lock
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pos_r    <= '0;
         locked_r <= 1'b0;
      end else if (bus.bit_tick) begin
         pos_r    <= pos_nxt;
         locked_r <= locked_nxt;
      end
   end

   // Serial drive, MSB first, only in own slots
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         shift_r     <= 8'h0;
         data_r      <= 1'b0;
         data_oe_n_r <= 1'b1;
      end else if (bus.bit_tick) begin
         // Enable moves only at slot starts; a mid-slot control write finishes the byte
         if (pos_nxt[2:0] == 3'h0) begin
            data_oe_n_r <= !(owned && locked_nxt);
            data_r  <= chan_data[7];
            shift_r <= {chan_data[6:0], 1'b0};
         end else begin
            data_r  <= shift_r[7];
            shift_r <= {shift_r[6:0], 1'b0};
         end
      end
   end

   // Sync generation; only legal in the first position
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fs_r <= 1'b0;
      end else if (bus.bit_tick) begin
         fs_r <= pos_nxt == last_pos;
      end
   end

   assign bus.dev_data_o    = data_r;
   assign bus.dev_data_oe_n = data_oe_n_r;
   assign bus.dev_fs_o      = fs_r;
   // Frame sync stays an input unless this device is its source
   assign bus.dev_fs_oe_n   = !(fs_master && position == 3'h0);
endmodule

// ===== ipbm_backplane.sv
`timescale 1ns/1ps
module ipbm_backplane #(
   parameter int TICK_DIV = ipbm_pkg::IPBM_DIV_FAST
) (
   // Clock and reset
   input  wire logic       aclk,
   input  wire logic       aresetn,
   // Bus configuration
   input  wire logic [1:0] bus_size,
   input  wire logic       style_frame,
   input  wire logic       fs_enable,
   // Received bytes
   output logic            rx_valid,
   output logic [2:0]      rx_stream,
   output logic [4:0]      rx_channel,
   output logic [7:0]      rx_byte,
   // Shared PCM bus
   ipbm_if.bp              bus
);
   localparam int SLOT_W = ipbm_pkg::IPBM_PCNT_W - 3;

   logic [9:0]                       div_r;
   logic [9:0]                       div_last;
   logic                             tick_r;
   logic [ipbm_pkg::IPBM_PCNT_W-1:0] pos_r;
   logic [ipbm_pkg::IPBM_PCNT_W-1:0] pos_nxt;
   logic [ipbm_pkg::IPBM_PCNT_W-1:0] last_pos;
   logic [ipbm_pkg::IPBM_FLEN_W-1:0] flen;
   logic [1:0]                       size_eff;
   logic [1:0]                       shamt;
   logic [SLOT_W-1:0]                slot;
   logic [6:0]                       shift_r;
   logic                             locked_r;
   logic                             fs_r;
   logic                             rx_valid_r;
   logic [2:0]                       rx_stream_r;
   logic [4:0]                       rx_channel_r;
   logic [7:0]                       rx_byte_r;

   // Reserved size runs as eight devices
   assign size_eff = (bus_size == ipbm_pkg::IPBM_SIZE_RSVD) ? ipbm_pkg::IPBM_SIZE_EIGHT : bus_size;
   assign shamt    = size_eff + 2'h1;
   // Slower rates are the fast divider doubled per halving; rates are approximate
   assign div_last = (10'(TICK_DIV) << (2'h2 - size_eff)) - 10'h1;

   // Bit tick divider
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_r  <= 10'h0;
         tick_r <= 1'b0;
      end else begin
         tick_r <= div_r >= div_last;
         div_r  <= (div_r >= div_last) ? 10'h0 : div_r + 10'h1;
      end
   end

   // Bit position of the bit now on the bus
   always_comb begin
      flen     = ipbm_pkg::IPBM_FLEN_W'(ipbm_pkg::IPBM_FRAME_BITS) << shamt;
      last_pos = ipbm_pkg::IPBM_PCNT_W'(flen - 12'h1);
      if (bus.frame_sync || pos_r >= last_pos) begin
         pos_nxt = '0;
      end else begin
         pos_nxt = pos_r + 11'h1;
      end
   end

   assign slot = pos_r[ipbm_pkg::IPBM_PCNT_W-1:3];

   // Position counter and sync lock
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pos_r    <= '0;
         locked_r <= 1'b0;
         fs_r     <= 1'b0;
      end else if (tick_r) begin
         pos_r    <= pos_nxt;
         locked_r <= locked_r || bus.frame_sync;
         fs_r     <= pos_nxt == last_pos;
      end
   end

   // Sample each bit, deliver a byte at the last bit of its slot
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         shift_r      <= 7'h0;
         rx_valid_r   <= 1'b0;
         rx_stream_r  <= 3'h0;
         rx_channel_r <= 5'h0;
         rx_byte_r    <= 8'h0;
      end else begin
         rx_valid_r <= 1'b0;
         if (tick_r && locked_r) begin
            shift_r <= {shift_r[5:0], bus.bus_data};
            if (pos_r[2:0] == 3'h7) begin
               rx_valid_r <= 1'b1;
               rx_byte_r  <= {shift_r, bus.bus_data};
               if (!style_frame) begin
                  rx_stream_r  <= 3'(slot & ((8'h1 << shamt) - 8'h1));
                  rx_channel_r <= 5'(slot >> shamt);
               end else begin
                  rx_stream_r  <= 3'(slot >> ipbm_pkg::IPBM_CHAN_W);
                  rx_channel_r <= slot[ipbm_pkg::IPBM_CHAN_W-1:0];
               end
            end
         end
      end
   end

   assign rx_valid       = rx_valid_r;
   assign rx_stream      = rx_stream_r;
   assign rx_channel     = rx_channel_r;
   assign rx_byte        = rx_byte_r;
   assign bus.bit_tick   = tick_r;
   assign bus.bp_fs_o    = fs_r;
   // Input unless the backplane is the sync source
   assign bus.bp_fs_oe_n = !fs_enable;
endmodule

// ===== ipbm_sva.sv
`timescale 1ns/1ps
module ipbm_sva #(
   parameter int TICK_DIV = 2
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Bus wires
   input wire logic bit_tick,
   input wire logic bp_fs_oe_n,
   input wire logic dev_fs_oe_n,
   input wire logic dev_data_oe_n,
   input wire logic frame_sync
);
   logic [11:0] pos_r;
   logic        synced_r;
   logic [3:0]  gap_r;
   logic        ticked_r;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // Bit position as the device counts it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pos_r    <= 12'h000;
         synced_r <= 1'b0;
      end else if (bit_tick) begin
         pos_r    <= frame_sync ? 12'h000 : pos_r + 12'h001;
         synced_r <= synced_r | frame_sync;
      end
   end
   // Cycles since last tick; saturates so a stall cannot wrap
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         gap_r    <= 4'h0;
         ticked_r <= 1'b0;
      end else if (bit_tick) begin
         gap_r    <= 4'h1;
         ticked_r <= 1'b1;
      end else if (gap_r != 4'hf) begin
         gap_r <= gap_r + 4'h1;
      end
   end
   sequence s_sync_bit;
      bit_tick && frame_sync;
   endsequence
   sequence s_quiet;
      !frame_sync [*2];
   endsequence
   chk_tick_pulse: assert property (bit_tick |=> !bit_tick)
      else $error("bit tick wider than one cycle");
   chk_tick_gap: assert property (bit_tick && ticked_r |-> gap_r == 4'(TICK_DIV)
      || gap_r == 4'(2 * TICK_DIV) || gap_r == 4'(4 * TICK_DIV)) else $error("bit rate off");
   chk_sync_one_bit: assert property (s_sync_bit |=> s_quiet)
      else $error("frame sync longer than one bit");
   chk_sync_spacing: assert property ((s_sync_bit and synced_r)
      |-> pos_r inside {12'h0ff, 12'h1ff, 12'h3ff, 12'h7ff}) else $error("frame length wrong");
   chk_one_sync_drv: assert property (!(!bp_fs_oe_n && !dev_fs_oe_n))
      else $error("two frame sync drivers");
   chk_data_at_tick: assert property ($changed(dev_data_oe_n) |-> $past(bit_tick))
      else $error("bus enable moved between ticks");
   chk_drive_start: assert property ($fell(dev_data_oe_n) && synced_r |-> pos_r[2:0] == 3'h0)
      else $error("drive began inside a slot");
   chk_drive_end: assert property ($rose(dev_data_oe_n) && synced_r |-> pos_r[2:0] == 3'h0)
      else $error("drive ended inside a slot");
endmodule

// ===== tb_interleaved_pcm_bus_mux.sv
`timescale 1ns/1ps
module tb_interleaved_pcm_bus_mux;
   localparam int TDIV = 2;
   localparam logic [11:0] A_CTL = {ipbm_pkg::IPBM_CTRL_IDX, 2'b00};
   localparam logic [11:0] A_CFG = {ipbm_pkg::IPBM_DEVCFG_IDX, 2'b00};
   localparam logic [11:0] A_STA = {ipbm_pkg::IPBM_STAT_IDX, 2'b00};
   // Host bus, source and backplane controls
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, chan_take, rx_valid;
   logic [11:0] awaddr = 12'h000, araddr = 12'h000;
   logic [31:0] wdata = 32'h0, rdata;
   logic [1:0]  bresp, rresp;
   logic [1:0]  bp_size = 2'h0;
   logic        bp_frame = 1'b0, bp_fs_en = 1'b1;
   logic [4:0]  chan_index, rx_channel;
   logic [7:0]  chan_data, rx_byte;
   logic [2:0]  rx_stream;
   // Expected setup and wire monitor state
   logic [7:0]  cfg_r = 8'h00;
   logic        mon_on = 1'b0, seen_fs = 1'b0;
   int          mon_pos = 0, miscompares = 0, samples_checked = 0, takes = 0;

   ipbm_if u_ipbm_if ();
   ipbm_dev u_ipbm_dev (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
      .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hf),
      .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
      .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
      .chan_index(chan_index), .chan_data(chan_data), .chan_take(chan_take), .bus(u_ipbm_if));
   ipbm_backplane #(.TICK_DIV(TDIV)) u_ipbm_backplane (.aclk(aclk), .aresetn(aresetn),
      .bus_size(bp_size), .style_frame(bp_frame), .fs_enable(bp_fs_en), .rx_valid(rx_valid),
      .rx_stream(rx_stream), .rx_channel(rx_channel), .rx_byte(rx_byte), .bus(u_ipbm_if));
   ipbm_sva #(.TICK_DIV(TDIV)) u_ipbm_sva (.aclk(aclk), .aresetn(aresetn),
      .bit_tick(u_ipbm_if.bit_tick), .bp_fs_oe_n(u_ipbm_if.bp_fs_oe_n),
      .dev_fs_oe_n(u_ipbm_if.dev_fs_oe_n), .dev_data_oe_n(u_ipbm_if.dev_data_oe_n),
      .frame_sync(u_ipbm_if.frame_sync));

   always #2.5 aclk = ~aclk;

   // Elastic store stand-in: byte tells its channel
   function automatic logic [7:0] byte_of(input logic [4:0] c);
      return {3'h5, c};
   endfunction
   assign chan_data = byte_of(chan_index);

   // Expected wire bit at frame bit p for the current setup
   function automatic logic exp_bit(input int p);
      int          s;
      int          n;
      logic        drv;
      logic [7:0]  b;
      s = p / 8;
      n = 2 << cfg_r[6:5];
      if (!cfg_r[3]) begin
         drv = (s < 32);
         b = byte_of(5'(s));
      end else if (cfg_r[6:5] == 2'h3) begin
         drv = 1'b0;
         b = 8'h00;
      end else if (cfg_r[4]) begin
         drv = (s / 32 == int'(cfg_r[2:0]));
         b = byte_of(5'(s % 32));
      end else begin
         drv = (s % n == int'(cfg_r[2:0]));
         b = byte_of(5'(s / n));
      end
      return drv & b[7 - p % 8];
   endfunction

   task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic print_verdict();
      if (miscompares == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic axi_write(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw_done;
      logic w_done;
      logic b_done;
      @(posedge aclk);
      {aw_done, w_done, b_done} = 3'h0;
      awaddr <= a;
      wdata <= d;
      {awvalid, wvalid, bready} <= 3'h7;
      while (!b_done) begin
         @(posedge aclk);
         if (!aw_done && awready) begin
            aw_done = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w_done && wready) begin
            w_done = 1'b1;
            wvalid <= 1'b0;
         end
         if (bvalid) begin
            b_done = 1'b1;
            r = bresp;
            bready <= 1'b0;
         end
      end
   endtask

   task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      logic a_done;
      logic got;
      @(posedge aclk);
      {a_done, got} = 2'h0;
      araddr <= a;
      {arvalid, rready} <= 2'h3;
      while (!got) begin
         @(posedge aclk);
         if (!a_done && arready) begin
            a_done = 1'b1;
            arvalid <= 1'b0;
         end
         if (rvalid) begin
            got = 1'b1;
            d = rdata;
            r = rresp;
            rready <= 1'b0;
         end
      end
   endtask

   task automatic wait_frames(input int n);
      repeat (n) begin
         @(posedge aclk);
         while (!(u_ipbm_if.bit_tick && u_ipbm_if.frame_sync)) begin
            @(posedge aclk);
         end
      end
   endtask

   task automatic do_reset(input logic [1:0] s, input logic f, input logic fe);
      aresetn <= 1'b0;
      bp_size <= s;
      bp_frame <= f;
      bp_fs_en <= fe;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
   endtask

   // Program, let two frames settle, then watch one whole frame
   task automatic run_cfg(input logic [7:0] c, input logic [7:0] dc);
      logic [1:0] r;
      int         n;
      axi_write(A_CFG, {24'h0, dc}, r);
      axi_write(A_CTL, {24'h0, c}, r);
      cmp_val(32'(r), 32'(ipbm_pkg::IPBM_RESP_OKAY));
      cfg_r = c;
      // Bytes pulled per bus frame: 32 when enabled, none when reserved
      n = !c[3] ? (64 << bp_size) : ((c[6:5] == 2'h3) ? 0 : 32);
      wait_frames(2);
      takes = 0;
      mon_on <= 1'b1;
      wait_frames(1);
      mon_on <= 1'b0;
      @(posedge aclk);
      cmp_val(32'(takes), 32'(n));
   endtask

   task automatic sc_regs();
      logic [31:0] d;
      logic [1:0]  r;
      do_reset(2'h1, 1'b0, 1'b1);
      axi_read(A_CTL, d, r);
      cmp_val(d, 32'(ipbm_pkg::IPBM_CTRL_RESET));
      axi_read(A_CFG, d, r);
      cmp_val(d, 32'(ipbm_pkg::IPBM_DEVCFG_RST));
      axi_write(A_CTL, 32'h0000_00ff, r);
      axi_read(A_CTL, d, r);
      cmp_val(d, 32'h0000_007f);
      axi_write(12'h400, 32'h1, r);
      cmp_val(32'(r), 32'(ipbm_pkg::IPBM_RESP_SLVERR));
      axi_read(12'h400, d, r);
      cmp_val({d[29:0], r}, {30'h0, ipbm_pkg::IPBM_RESP_SLVERR});
   endtask

   task automatic sc_chan_four();
      do_reset(2'h1, 1'b0, 1'b1);
      run_cfg(8'h2a, 8'h00);
   endtask

   task automatic sc_frame_eight();
      do_reset(2'h2, 1'b1, 1'b1);
      run_cfg(8'h5f, 8'h00);
   endtask

   // First device makes the sync; backplane sync left as input
   task automatic sc_dev_sync();
      logic [31:0] d;
      logic [1:0]  r;
      do_reset(2'h0, 1'b0, 1'b0);
      run_cfg(8'h08, 8'h01);
      axi_read(A_STA, d, r);
      cmp_val(d & 32'h9, 32'h9);
   endtask

   task automatic sc_disabled();
      do_reset(2'h0, 1'b0, 1'b1);
      run_cfg(8'h03, 8'h00);
   endtask

   task automatic sc_reserved();
      logic [31:0] d;
      logic [1:0]  r;
      do_reset(2'h2, 1'b0, 1'b1);
      run_cfg(8'h6d, 8'h00);
      axi_read(A_STA, d, r);
      cmp_val(d & 32'h5, 32'h5);
   endtask

   // Wire monitor: bit sampled at a tick was driven at the tick before
   always @(posedge aclk) begin
      if (!aresetn) begin
         seen_fs = 1'b0;
      end else if (u_ipbm_if.bit_tick) begin
         if (mon_on && seen_fs && (cfg_r[3] || mon_pos < 256)) begin
            cmp_val({31'h0, u_ipbm_if.bus_data}, {31'h0, exp_bit(mon_pos)});
         end
         mon_pos = u_ipbm_if.frame_sync ? 0 : mon_pos + 1;
         seen_fs = seen_fs | u_ipbm_if.frame_sync;
      end
   end

   // Source pulls counted over the watched frame
   always @(posedge aclk) begin
      if (mon_on && chan_take) begin
         takes++;
      end
   end

   // Backplane receive side: own slots carry the right byte, others stay low
   always @(posedge aclk) begin
      if (mon_on && rx_valid && cfg_r[3] && cfg_r[6:5] != 2'h3) begin
         cmp_val({24'h0, rx_byte}, {24'h0, (rx_stream == cfg_r[2:0]) ? byte_of(rx_channel) : 8'h00});
      end
   end

   initial begin
      sc_regs();
      sc_chan_four();
      sc_frame_eight();
      sc_dev_sync();
      sc_disabled();
      sc_reserved();
      print_verdict();
   end

   // Watchdog, sized for five runs of about three frames each
   initial begin
      #475000;
      miscompares++;
      print_verdict();
   end
endmodule
